// ### hw/pfr_params.svh
// Offsets, field positions and reset values of the programmable CPU frequency registers.
// Assumes an 8-bit register index carried by the link write/read request.
`ifndef PFR_PARAMS_SVH
`define PFR_PARAMS_SVH

`define PFR_ADDR_N_VALUE     8'h0d
`define PFR_ADDR_M_VALUE     8'h0e
`define PFR_ADDR_RSVD_A      8'h0f
`define PFR_ADDR_RSVD_B      8'h10

`define PFR_EN_BIT           7
`define PFR_M_MSB            6
`define PFR_SEL_MSB          4

`define PFR_RST_N_VALUE      8'h00
`define PFR_RST_M_VALUE      8'h00
`define PFR_RST_RSVD_A       8'h03
`define PFR_RST_RSVD_B       8'h00
`define PFR_RST_RATIO_SEL    5'h00
`define PFR_UNMAPPED_RDATA   8'h00

`endif

// ### hw/pfr_pkg.sv
// Types shared by the programmable CPU frequency register bank.
// Assumes pfr_params.svh supplies all numeric constants.
package pfr_pkg;

	typedef logic [7:0] pfr_byte_t;

	typedef enum logic [0:0] {
		PFR_LINK_IDLE = 1'b0,
		PFR_LINK_WAIT = 1'b1
	} pfr_link_state_e;

endpackage

// ### hw/pfr_link_port.sv
// Link-clock front end: takes byte read/write requests and hands them to the core domain.
// Assumes the core returns a done toggle and holds its read data stable until the next request.
module pfr_link_port (
	input  wire logic           link_clk,
	input  wire logic           nrst,
	input  wire logic           link_req,
	input  wire logic           link_we,
	input  wire logic [7:0]     link_addr,
	input  wire logic [7:0]     link_wdata,
	output logic                link_busy,
	output logic                link_rvalid,
	output logic [7:0]          link_rdata,
	output logic                xfer_toggle,
	output logic                xfer_we,
	output logic [7:0]          xfer_addr,
	output logic [7:0]          xfer_wdata,
	input  wire logic           done_toggle,
	input  wire logic [7:0]     core_rdata
);

	logic                       rst_meta;
	logic                       rst_n;
	logic                       done_meta;
	logic                       done_s1;
	logic                       done_s2;
	logic                       done_seen;
	pfr_pkg::pfr_link_state_e   state_reg;
	pfr_pkg::pfr_link_state_e   state_next;
	logic                       busy_next;
	logic                       rvalid_next;
	logic [7:0]                 rdata_next;
	logic                       tog_next;
	logic                       we_next;
	logic [7:0]                 addr_next;
	logic [7:0]                 wdata_next;

	////////////////////////////////////////////////////////////////////////
	// Reset release and done synchroniser
	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta  <= 1'b0;
			rst_n     <= 1'b0;
			done_meta <= 1'b0;
			done_s1   <= 1'b0;
			done_s2   <= 1'b0;
		end else begin
			rst_meta  <= 1'b1;
			rst_n     <= rst_meta;
			done_meta <= done_toggle;
			done_s1   <= done_meta;
			done_s2   <= done_s1;
		end
	end

	assign done_seen = done_s1 ^ done_s2;

	////////////////////////////////////////////////////////////////////////
	// Request handshake
	always_comb begin
		state_next  = state_reg;
		busy_next   = link_busy;
		rvalid_next = 1'b0;
		rdata_next  = link_rdata;
		tog_next    = xfer_toggle;
		we_next     = xfer_we;
		addr_next   = xfer_addr;
		wdata_next  = xfer_wdata;
		case (state_reg)
			pfr_pkg::PFR_LINK_IDLE: begin
				if (link_req) begin
					we_next    = link_we;
					addr_next  = link_addr;
					wdata_next = link_wdata;
					tog_next   = ~xfer_toggle;
					busy_next  = 1'b1;
					state_next = pfr_pkg::PFR_LINK_WAIT;
				end
			end
			pfr_pkg::PFR_LINK_WAIT: begin
				if (done_seen) begin
					busy_next   = 1'b0;
					rvalid_next = ~xfer_we;
					if (!xfer_we) begin
						rdata_next = core_rdata;
					end
					state_next  = pfr_pkg::PFR_LINK_IDLE;
				end
			end
			default: begin
				busy_next  = 1'b0;
				state_next = pfr_pkg::PFR_LINK_IDLE;
			end
		endcase
	end

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg   <= pfr_pkg::PFR_LINK_IDLE;
			link_busy   <= 1'b0;
			link_rvalid <= 1'b0;
			link_rdata  <= 8'h00;
			xfer_toggle <= 1'b0;
			xfer_we     <= 1'b0;
			xfer_addr   <= 8'h00;
			xfer_wdata  <= 8'h00;
		end else begin
			state_reg   <= state_next;
			link_busy   <= busy_next;
			link_rvalid <= rvalid_next;
			link_rdata  <= rdata_next;
			xfer_toggle <= tog_next;
			xfer_we     <= we_next;
			xfer_addr   <= addr_next;
			xfer_wdata  <= wdata_next;
		end
	end

	a_busy_while_wait: assert property (@(posedge link_clk) disable iff (!rst_n)
		(state_reg == pfr_pkg::PFR_LINK_WAIT) |-> link_busy)
		else $error("link busy low while waiting");

endmodule

// ### hw/pfr_regs.sv
// Programmable CPU frequency register bank: N value, M value with enable, two reserved bytes.
// Assumes a link-side logic master on link_clk and synthesizer/ratio logic on clk.
`include "pfr_params.svh"

// Summary of operation
// R1: Bit 7 of the M-value byte enables the programmable frequency, 0 off and 1 on.
// R2: With the enable set, the CPU frequency comes from the 8-bit N and 7-bit M values.
// R3: A write to the M byte starts loading the new frequency, an N-only write does not.
// R4: The clock ratio uses the strap selection when override is clear, software otherwise.
// R5: The host picks N and M that keep the CPU frequency within 50 MHz to 248 MHz.
// R6: The host writes ones to the two low bits of the first reserved byte, which reset to one.
// R7: With the enable clear, the stored N and M are ignored and the hardware setting stays.
module pfr_regs (
	input  wire logic           clk,
	input  wire logic           nrst,
	input  wire logic           link_clk,
	input  wire logic           link_req,
	input  wire logic           link_we,
	input  wire logic [7:0]     link_addr,
	input  wire logic [7:0]     link_wdata,
	output logic                link_busy,
	output logic                link_rvalid,
	output logic [7:0]          link_rdata,
	input  wire logic           ratio_source_override,
	input  wire logic [4:0]     sw_freq_select,
	input  wire logic [4:0]     strap_latched_freq_select,
	output logic [7:0]          cpu_synth_n_value,
	output logic [6:0]          cpu_synth_m_value,
	output logic                prog_freq_enable,
	output logic                freq_load,
	output logic [4:0]          ratio_select
);

	logic                       rst_meta;
	logic                       rst_n;
	logic                       xfer_toggle;
	logic                       xfer_we;
	logic [7:0]                 xfer_addr;
	logic [7:0]                 xfer_wdata;
	logic                       req_meta;
	logic                       req_s1;
	logic                       req_s2;
	logic                       req_seen;
	logic                       wr_n;
	logic                       wr_m;
	logic                       wr_en_bit;
	pfr_pkg::pfr_byte_t         n_reg;
	pfr_pkg::pfr_byte_t         n_next;
	pfr_pkg::pfr_byte_t         m_reg;
	pfr_pkg::pfr_byte_t         m_next;
	pfr_pkg::pfr_byte_t         rsvd_a_reg;
	pfr_pkg::pfr_byte_t         rsvd_a_next;
	pfr_pkg::pfr_byte_t         rsvd_b_reg;
	pfr_pkg::pfr_byte_t         rsvd_b_next;
	pfr_pkg::pfr_byte_t         rdata_reg;
	pfr_pkg::pfr_byte_t         rdata_next;
	logic                       done_reg;
	logic                       done_next;
	logic                       load_next;
	logic [4:0]                 ratio_next;

	////////////////////////////////////////////////////////////////////////
	// Reset release and request synchroniser
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
			req_meta <= 1'b0;
			req_s1   <= 1'b0;
			req_s2   <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
			req_meta <= xfer_toggle;
			req_s1   <= req_meta;
			req_s2   <= req_s1;
		end
	end

	assign req_seen  = req_s1 ^ req_s2;
	assign wr_n      = req_seen & xfer_we & (xfer_addr == `PFR_ADDR_N_VALUE);
	assign wr_m      = req_seen & xfer_we & (xfer_addr == `PFR_ADDR_M_VALUE);
	assign wr_en_bit = xfer_wdata[`PFR_EN_BIT];

	////////////////////////////////////////////////////////////////////////
	// Link front end
	pfr_link_port u_link (
		.link_clk    (link_clk),
		.nrst        (nrst),
		.link_req    (link_req),
		.link_we     (link_we),
		.link_addr   (link_addr),
		.link_wdata  (link_wdata),
		.link_busy   (link_busy),
		.link_rvalid (link_rvalid),
		.link_rdata  (link_rdata),
		.xfer_toggle (xfer_toggle),
		.xfer_we     (xfer_we),
		.xfer_addr   (xfer_addr),
		.xfer_wdata  (xfer_wdata),
		.done_toggle (done_reg),
		.core_rdata  (rdata_reg)
	);

	////////////////////////////////////////////////////////////////////////
	// Register writes and reads
	always_comb begin
		n_next      = n_reg;
		m_next      = m_reg;
		rsvd_a_next = rsvd_a_reg;
		rsvd_b_next = rsvd_b_reg;
		rdata_next  = rdata_reg;
		done_next   = done_reg;
		if (req_seen) begin
			done_next = ~done_reg;
			if (xfer_we) begin
				case (xfer_addr)
					`PFR_ADDR_N_VALUE: begin
						n_next = xfer_wdata;
					end
					// R1: enable bit with M
					`PFR_ADDR_M_VALUE: begin
						m_next = xfer_wdata;
					end
					`PFR_ADDR_RSVD_A: begin
						rsvd_a_next = xfer_wdata;
					end
					`PFR_ADDR_RSVD_B: begin
						rsvd_b_next = xfer_wdata;
					end
					default: begin
						n_next = n_reg;
					end
				endcase
			end else begin
				case (xfer_addr)
					`PFR_ADDR_N_VALUE: begin
						rdata_next = n_reg;
					end
					`PFR_ADDR_M_VALUE: begin
						rdata_next = m_reg;
					end
					`PFR_ADDR_RSVD_A: begin
						rdata_next = rsvd_a_reg;
					end
					`PFR_ADDR_RSVD_B: begin
						rdata_next = rsvd_b_reg;
					end
					default: begin
						rdata_next = `PFR_UNMAPPED_RDATA;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			n_reg      <= `PFR_RST_N_VALUE;
			m_reg      <= `PFR_RST_M_VALUE;
			rsvd_a_reg <= `PFR_RST_RSVD_A;
			rsvd_b_reg <= `PFR_RST_RSVD_B;
			rdata_reg  <= `PFR_UNMAPPED_RDATA;
			done_reg   <= 1'b0;
		end else begin
			n_reg      <= n_next;
			m_reg      <= m_next;
			rsvd_a_reg <= rsvd_a_next;
			rsvd_b_reg <= rsvd_b_next;
			rdata_reg  <= rdata_next;
			done_reg   <= done_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Synthesizer controls
	always_comb begin
		// R3: load only on M write
		// R7: no load while disabled
		load_next  = wr_m & wr_en_bit;
		// R4: ratio source select
		ratio_next = ratio_source_override ? sw_freq_select : strap_latched_freq_select;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_synth_n_value <= `PFR_RST_N_VALUE;
			cpu_synth_m_value <= 7'(`PFR_RST_M_VALUE);
			prog_freq_enable  <= 1'b0;
			freq_load         <= 1'b0;
			ratio_select      <= `PFR_RST_RATIO_SEL;
		end else begin
			// R2: N and M to synthesizer
			cpu_synth_n_value <= n_next;
			cpu_synth_m_value <= m_next[`PFR_M_MSB:0];
			// R1: enable output
			prog_freq_enable  <= m_next[`PFR_EN_BIT];
			freq_load         <= load_next;
			ratio_select      <= ratio_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_load_on_mwrite: assert property (@(posedge clk) disable iff (!rst_n) // R3
		(wr_m && wr_en_bit) |=> freq_load)
		else $error("M write with enable did not load");

	a_no_load_nwrite: assert property (@(posedge clk) disable iff (!rst_n) // R3
		wr_n |=> !freq_load)
		else $error("N write started a load");

	a_enable_bit: assert property (@(posedge clk) disable iff (!rst_n) // R1
		wr_m |=> (prog_freq_enable == $past(wr_en_bit)))
		else $error("enable bit not taken from M byte");

	a_m_value: assert property (@(posedge clk) disable iff (!rst_n) // R2
		wr_m |=> (cpu_synth_m_value == $past(xfer_wdata[`PFR_M_MSB:0])))
		else $error("M value not passed on");

	a_n_value: assert property (@(posedge clk) disable iff (!rst_n) // R2
		wr_n |=> (cpu_synth_n_value == $past(xfer_wdata)) && $stable(cpu_synth_m_value))
		else $error("N value not passed on");

	a_ratio_strap: assert property (@(posedge clk) disable iff (!rst_n) // R4
		!ratio_source_override |=> (ratio_select == $past(strap_latched_freq_select)))
		else $error("ratio not from strap selection");

	a_ratio_soft: assert property (@(posedge clk) disable iff (!rst_n) // R4
		ratio_source_override |=> (ratio_select == $past(sw_freq_select)))
		else $error("ratio not from software selection");

	a_load_needs_en: assert property (@(posedge clk) disable iff (!rst_n) // R7
		freq_load |-> prog_freq_enable)
		else $error("load while programmable frequency disabled");

	a_done_answer: assert property (@(posedge clk) disable iff (!rst_n)
		req_seen |=> (done_reg != $past(done_reg)))
		else $error("request not answered");

endmodule

// ### testbench/pfr_host_model.sv
// Link-side host model: single byte writes and reads on the request port.
// Assumes the bank answers by dropping busy, with rvalid in that cycle for reads.
module pfr_host_model (
	input  wire logic           link_clk,
	input  wire logic           link_busy,
	input  wire logic           link_rvalid,
	input  wire logic [7:0]     link_rdata,
	output logic                link_req,
	output logic                link_we,
	output logic [7:0]          link_addr,
	output logic [7:0]          link_wdata
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] last_rdata;
	logic       xfer_ok;

	initial begin
		link_req   = 1'b0;
		link_we    = 1'b0;
		link_addr  = 8'h00;
		link_wdata = 8'h00;
		last_rdata = 8'h00;
		xfer_ok    = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Request held for one link clock, then released lines show inverted values
	task automatic xfer(input logic we, input logic [7:0] addr, input logic [7:0] wdata);
		int n;
		n = 0;
		@(posedge link_clk);
		link_req   <= 1'b1;
		link_we    <= we;
		link_addr  <= addr;
		link_wdata <= wdata;
		do begin
			@(posedge link_clk);
			n++;
		end while (link_busy !== 1'b0 && n < 40);
		link_req   <= 1'b0;
		link_we    <= ~we;
		link_addr  <= ~addr;
		link_wdata <= ~wdata;
		do begin
			@(posedge link_clk);
			n++;
		end while (link_busy !== 1'b1 && n < 44);
		do begin
			@(posedge link_clk);
			n++;
		end while (link_busy !== 1'b0 && n < 80);
		last_rdata = link_rdata;
		xfer_ok    = (n < 80) && (we || link_rvalid === 1'b1);
	endtask

endmodule

// ### testbench/tb.sv
// Testbench for the programmable CPU frequency register bank.
// Assumes pfr_host_model drives the link port and pfr_params.svh holds the map.
`include "pfr_params.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk;
	logic       link_clk;
	logic       nrst;
	logic       link_req;
	logic       link_we;
	logic [7:0] link_addr;
	logic [7:0] link_wdata;
	logic       link_busy;
	logic       link_rvalid;
	logic [7:0] link_rdata;
	logic       ratio_source_override;
	logic [4:0] sw_freq_select;
	logic [4:0] strap_latched_freq_select;
	logic [7:0] cpu_synth_n_value;
	logic [6:0] cpu_synth_m_value;
	logic       prog_freq_enable;
	logic       freq_load;
	logic [4:0] ratio_select;
	logic [7:0] load_count;
	logic [7:0] base;
	int         err_total;
	int         check_count;

	initial clk = 1'b0;
	always #10 clk = ~clk;
	initial link_clk = 1'b0;
	always #6 link_clk = ~link_clk;

	// Load pulses counted, cleared while reset is held
	always @(posedge clk) begin
		if (nrst !== 1'b1) begin
			load_count <= 8'h00;
		end else if (freq_load === 1'b1) begin
			load_count <= load_count + 8'h01;
		end
	end

	pfr_regs uut (
		.clk                       (clk),
		.nrst                      (nrst),
		.link_clk                  (link_clk),
		.link_req                  (link_req),
		.link_we                   (link_we),
		.link_addr                 (link_addr),
		.link_wdata                (link_wdata),
		.link_busy                 (link_busy),
		.link_rvalid               (link_rvalid),
		.link_rdata                (link_rdata),
		.ratio_source_override     (ratio_source_override),
		.sw_freq_select            (sw_freq_select),
		.strap_latched_freq_select (strap_latched_freq_select),
		.cpu_synth_n_value         (cpu_synth_n_value),
		.cpu_synth_m_value         (cpu_synth_m_value),
		.prog_freq_enable          (prog_freq_enable),
		.freq_load                 (freq_load),
		.ratio_select              (ratio_select)
	);

	pfr_host_model host (
		.link_clk    (link_clk),
		.link_busy   (link_busy),
		.link_rvalid (link_rvalid),
		.link_rdata  (link_rdata),
		.link_req    (link_req),
		.link_we     (link_we),
		.link_addr   (link_addr),
		.link_wdata  (link_wdata)
	);

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.xfer(1'b1, a, d);
		check("write answer", {7'h00, host.xfer_ok}, 8'h01);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		host.xfer(1'b0, a, ~exp);
		check("read answer", {7'h00, host.xfer_ok}, 8'h01);
		check("read data", host.last_rdata, exp);
	endtask

	task automatic results;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		nrst = 1'b0;
		err_total = 0;
		check_count = 0;
		ratio_source_override = 1'b0;
		sw_freq_select = 5'h00;
		strap_latched_freq_select = 5'h00;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (5) @(posedge clk);
		check("enable", {7'h00, prog_freq_enable}, 8'h00);
		rd(`PFR_ADDR_N_VALUE, `PFR_RST_N_VALUE);
		rd(`PFR_ADDR_M_VALUE, `PFR_RST_M_VALUE);
		rd(`PFR_ADDR_RSVD_A, `PFR_RST_RSVD_A);
		rd(`PFR_ADDR_RSVD_B, `PFR_RST_RSVD_B);
		rd(8'h11, `PFR_UNMAPPED_RDATA);
		base = load_count;
		// N and M picked inside the supported frequency range
		wr(`PFR_ADDR_N_VALUE, 8'h40);
		check("n value", cpu_synth_n_value, 8'h40);
		check("load count", load_count, base);
		wr(`PFR_ADDR_M_VALUE, 8'h85);
		check("enable", {7'h00, prog_freq_enable}, 8'h01);
		check("m value", {1'b0, cpu_synth_m_value}, 8'h05);
		check("load count", load_count, base + 8'h01);
		rd(`PFR_ADDR_M_VALUE, 8'h85);
		wr(`PFR_ADDR_M_VALUE, 8'h07);
		check("enable", {7'h00, prog_freq_enable}, 8'h00);
		check("load count", load_count, base + 8'h01);
		wr(`PFR_ADDR_M_VALUE, 8'h86);
		wr(`PFR_ADDR_M_VALUE, 8'h87);
		check("load count", load_count, base + 8'h03);
		check("m value", {1'b0, cpu_synth_m_value}, 8'h07);
		// Low two bits of reserved A always written as ones
		wr(`PFR_ADDR_RSVD_A, 8'h53);
		rd(`PFR_ADDR_RSVD_A, 8'h53);
		wr(`PFR_ADDR_RSVD_B, 8'ha5);
		rd(`PFR_ADDR_RSVD_B, 8'ha5);
		wr(8'h20, 8'h5a);
		rd(8'h20, `PFR_UNMAPPED_RDATA);
		rd(`PFR_ADDR_N_VALUE, 8'h40);
		for (int ov = 0; ov < 2; ov++) begin
			for (int c = 0; c < 32; c++) begin
				@(posedge clk);
				ratio_source_override <= ov[0];
				sw_freq_select <= c[4:0];
				strap_latched_freq_select <= ~c[4:0];
				repeat (3) @(posedge clk);
				check("ratio", {3'h0, ratio_select}, {3'h0, ov ? c[4:0] : ~c[4:0]});
			end
		end
		results;
	end

	initial begin
		#200us;
		err_total++;
		results;
	end

endmodule
